/* File: dsr_regs.svh */
// constants for the deep sleep release and identifier command path
// assumes a 25 MHz system clock and an 8-bit opcode shifted msb first
`ifndef DSR_REGS_SVH
`define DSR_REGS_SVH

// ****************************************************************
// opcodes and frame layout
// ****************************************************************
`define DSR_OP_RELEASE 8'hAB
`define DSR_OP_ENTRY 8'hB9
`define DSR_OP_BITS 5'h08
`define DSR_DUMMY_CLKS 5'h03
`define DSR_STREAM_START (`DSR_OP_BITS + `DSR_DUMMY_CLKS)
`define DSR_ID_WIDTH 16
`define DSR_ID_LAST 4'hF

// ****************************************************************
// pin positions in the synchroniser vector
// ****************************************************************
`define DSR_PIN_CS 0
`define DSR_PIN_SCK 1
`define DSR_PIN_MOSI 2
`define DSR_PIN_COUNT 3

// ****************************************************************
// timing
// ****************************************************************
`define DSR_CLK_PERIOD_NS 40
`define DSR_SBR_TIME_NS 10000
`define DSR_SBR_CYCLES (`DSR_SBR_TIME_NS / `DSR_CLK_PERIOD_NS)
`define DSR_TIMER_WIDTH 8

`endif

/* File: dsr_pkg.sv */
// types shared by the deep sleep release blocks
// assumes dsr_regs.svh for widths
`default_nettype none
`include "dsr_regs.svh"

package dsr_pkg;
    // power state of the device
    typedef enum logic [1:0]
    {
        DSR_PS_STANDBY = 2'b00,
        DSR_PS_SLEEP = 2'b01,
        DSR_PS_WAKE = 2'b10
    } dsr_pwr_t;

    typedef logic [`DSR_ID_WIDTH-1:0] dsr_word_t;
endpackage : dsr_pkg

`default_nettype wire

/* File: dsr_buf_if.sv */
// handshake bundle between the command path and its identifier buffer
// assumes one clock domain for both ends
`timescale 1ns/1ps
`default_nettype none

interface dsr_buf_if;
    logic in_valid;
    logic in_ready;
    dsr_pkg::dsr_word_t in_data;
    logic out_valid;
    logic out_ready;
    dsr_pkg::dsr_word_t out_data;

    modport fill (output in_valid, output in_data, input in_ready,
                  input out_valid, input out_data, output out_ready);
    modport store (input in_valid, input in_data, output in_ready,
                   output out_valid, output out_data, input out_ready);
endinterface : dsr_buf_if

`default_nettype wire

/* File: dsr_fifo2.sv */
// two-entry buffer for identifier words
// assumes synchronous valid/ready on both sides, one clock
`timescale 1ns/1ps
`default_nettype none

module dsr_fifo2 (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    dsr_buf_if.store bus
);
    dsr_pkg::dsr_word_t mem_q [2];
    dsr_pkg::dsr_word_t mem_d [2];
    logic wr_q, wr_d, rd_q, rd_d, rdy_q, rdy_d;
    logic [1:0] cnt_q, cnt_d;
    logic push, pop;

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb
    begin
        push = bus.in_valid & rdy_q;
        pop = bus.out_ready & (cnt_q != 2'h0);
        mem_d = mem_q;
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        if (push)
        begin
            mem_d[wr_q] = bus.in_data;
            wr_d = ~wr_q;
        end
        if (pop)
        begin
            rd_d = ~rd_q;
        end
        if (push && !pop)
        begin
            cnt_d = cnt_q + 2'h1;
        end
        else if (pop && !push)
        begin
            cnt_d = cnt_q - 2'h1;
        end
        // registered ready keeps the source side free of combinational paths
        rdy_d = (cnt_d != 2'h2);
    end

    // registers only
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            cnt_q <= 2'h0;
            rdy_q <= 1'b0;
        end
        else
        begin
            mem_q <= mem_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
            rdy_q <= rdy_d;
        end
    end

    assign bus.in_ready = rdy_q;
    assign bus.out_valid = (cnt_q != 2'h0);
    assign bus.out_data = mem_q[rd_q];
endmodule : dsr_fifo2

`default_nettype wire

/* File: dsr_top.sv */
// serial command path that releases the device from deep sleep
// and streams the part identifier; serial pins are oversampled by
// the 25 MHz system clock, the serial clock is not used as a clock
`timescale 1ns/1ps
`default_nettype none
`include "dsr_regs.svh"

module dsr_top (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic mosi_i,
    input wire logic busy_i,
    input wire dsr_pkg::dsr_word_t part_id_i,
    input wire logic part_id_valid_i,
    output logic part_id_ready_o,
    output logic miso_o,
    output logic miso_oe_o,
    output logic deep_sleep_o,
    output logic standby_o
);
    localparam int CHK_WAKE_MAX = `DSR_SBR_CYCLES;

    dsr_buf_if buf_bus ();

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [`DSR_PIN_COUNT-1:0] s1_q, s2_q, s3_q, filt_q, prev_q;
    logic [`DSR_PIN_COUNT-1:0] filt_d, pins;
    logic active, cs_rise, sck_rise, sck_fall, mosi;

    // a change counts only once stages two and three agree
    always_comb
    begin
        pins = '0;
        pins[`DSR_PIN_CS] = cs_n_i;
        pins[`DSR_PIN_SCK] = sclk_i;
        pins[`DSR_PIN_MOSI] = mosi_i;
        filt_d = (s3_q & ~(s2_q ^ s3_q)) | (filt_q & (s2_q ^ s3_q));
    end

    // stage one feeds only stage two
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s1_q <= 3'h7;
            s2_q <= 3'h7;
            s3_q <= 3'h7;
            filt_q <= 3'h7;
            prev_q <= 3'h7;
        end
        else
        begin
            s1_q <= pins;
            s2_q <= s1_q;
            s3_q <= s2_q;
            filt_q <= filt_d;
            prev_q <= filt_q;
        end
    end

    // edge strobes of the filtered pins
    assign active = ~filt_q[`DSR_PIN_CS];
    assign cs_rise = filt_q[`DSR_PIN_CS] & ~prev_q[`DSR_PIN_CS];
    assign sck_rise = filt_q[`DSR_PIN_SCK] & ~prev_q[`DSR_PIN_SCK];
    assign sck_fall = ~filt_q[`DSR_PIN_SCK] & prev_q[`DSR_PIN_SCK];
    assign mosi = filt_q[`DSR_PIN_MOSI];

    // ****************************************************************
    // frame decode, power state and identifier shifter
    // ****************************************************************
    dsr_pkg::dsr_pwr_t ps_q, ps_d;
    logic [`DSR_TIMER_WIDTH-1:0] tmr_q, tmr_d;
    logic [4:0] bit_q, bit_d;
    logic [7:0] sh_in_q, sh_in_d, opcode;
    logic rel_q, rel_d, ent_q, ent_d, miso_q, miso_d, oe_q, oe_d;
    dsr_pkg::dsr_word_t sh_out_q, sh_out_d, word;
    logic [3:0] obits_q, obits_d;
    logic pop, load;

    always_comb
    begin
        ps_d = ps_q;
        tmr_d = tmr_q;
        bit_d = bit_q;
        sh_in_d = sh_in_q;
        rel_d = rel_q;
        ent_d = ent_q;
        miso_d = miso_q;
        oe_d = oe_q;
        sh_out_d = sh_out_q;
        obits_d = obits_q;
        pop = 1'b0;
        opcode = {sh_in_q[6:0], mosi};
        load = (obits_q == 4'h0);
        word = buf_bus.out_valid ? buf_bus.out_data : '0;
        // standby return countdown; frames are not taken meanwhile
        if (ps_q == dsr_pkg::DSR_PS_WAKE)
        begin
            tmr_d = tmr_q - 8'h01;
            if (tmr_q == 8'h01)
            begin
                ps_d = dsr_pkg::DSR_PS_STANDBY;
            end
        end
        if (!active || ps_q == dsr_pkg::DSR_PS_WAKE)
        begin
            bit_d = 5'h00;
            obits_d = 4'h0;
        end
        else if (sck_rise)
        begin
            sh_in_d = opcode;
            if (bit_q != `DSR_STREAM_START)
            begin
                bit_d = bit_q + 5'h01;
            end
            if (bit_q == `DSR_OP_BITS - 5'h01)
            begin
                rel_d = (opcode == `DSR_OP_RELEASE);
                // in sleep only the release opcode is decoded
                ent_d = (opcode == `DSR_OP_ENTRY) && (ps_q != dsr_pkg::DSR_PS_SLEEP);
            end
        end
        else if (sck_fall && rel_q && bit_q == `DSR_STREAM_START)
        begin
            // continuous stream; word refills from the buffer every 16 bits
            oe_d = 1'b1;
            if (load)
            begin
                pop = 1'b1;
                miso_d = word[`DSR_ID_WIDTH-1];
                sh_out_d = {word[`DSR_ID_WIDTH-2:0], 1'b0};
                obits_d = `DSR_ID_LAST;
            end
            else
            begin
                miso_d = sh_out_q[`DSR_ID_WIDTH-1];
                sh_out_d = {sh_out_q[`DSR_ID_WIDTH-2:0], 1'b0};
                obits_d = obits_q - 4'h1;
            end
        end
        // end of frame: act on the decoded opcode
        if (cs_rise)
        begin
            oe_d = 1'b0;
            rel_d = 1'b0;
            ent_d = 1'b0;
            if (rel_q && ps_q == dsr_pkg::DSR_PS_SLEEP)
            begin
                ps_d = dsr_pkg::DSR_PS_WAKE;
                tmr_d = `DSR_TIMER_WIDTH'(`DSR_SBR_CYCLES);
            end
            else if (ent_q && !busy_i && ps_q == dsr_pkg::DSR_PS_STANDBY)
            begin
                ps_d = dsr_pkg::DSR_PS_SLEEP;
            end
        end
    end

    // registers only
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ps_q <= dsr_pkg::DSR_PS_STANDBY;
            tmr_q <= '0;
            bit_q <= '0;
            sh_in_q <= '0;
            rel_q <= 1'b0;
            ent_q <= 1'b0;
            miso_q <= 1'b0;
            oe_q <= 1'b0;
            sh_out_q <= '0;
            obits_q <= '0;
            deep_sleep_o <= 1'b0;
            standby_o <= 1'b1;
        end
        else
        begin
            ps_q <= ps_d;
            tmr_q <= tmr_d;
            bit_q <= bit_d;
            sh_in_q <= sh_in_d;
            rel_q <= rel_d;
            ent_q <= ent_d;
            miso_q <= miso_d;
            oe_q <= oe_d;
            sh_out_q <= sh_out_d;
            obits_q <= obits_d;
            deep_sleep_o <= (ps_d == dsr_pkg::DSR_PS_SLEEP);
            standby_o <= (ps_d == dsr_pkg::DSR_PS_STANDBY);
        end
    end

    // ****************************************************************
    // identifier buffer; ready is a flop inside the buffer
    // ****************************************************************
    assign buf_bus.in_valid = part_id_valid_i;
    assign buf_bus.in_data = part_id_i;
    assign buf_bus.out_ready = pop;
    assign part_id_ready_o = buf_bus.in_ready;
    assign miso_o = miso_q;
    assign miso_oe_o = oe_q;

    dsr_fifo2 u_buf (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .bus(buf_bus.store)
    );

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    chk_release_wake: assert property (
        cs_rise && rel_q && ps_q == dsr_pkg::DSR_PS_SLEEP |=> ps_q == dsr_pkg::DSR_PS_WAKE)
        else $error("release frame did not start wake");
    chk_wake_bound: assert property (
        ps_q == dsr_pkg::DSR_PS_WAKE && $past(ps_q) != dsr_pkg::DSR_PS_WAKE
        |-> ##[1:CHK_WAKE_MAX] ps_q == dsr_pkg::DSR_PS_STANDBY)
        else $error("standby not reached in time");
    chk_wake_hold: assert property (
        ps_q == dsr_pkg::DSR_PS_WAKE && $past(ps_q) != dsr_pkg::DSR_PS_WAKE
        |-> (ps_q == dsr_pkg::DSR_PS_WAKE && bit_q == 5'h00)[*8])
        else $error("wake ended early or frame taken");
    chk_sleep_ignore: assert property (
        ps_q == dsr_pkg::DSR_PS_SLEEP && cs_rise && !rel_q |=> ps_q == dsr_pkg::DSR_PS_SLEEP)
        else $error("sleep left without release");
    chk_entry_sleep: assert property (
        ps_q == dsr_pkg::DSR_PS_STANDBY && cs_rise && ent_q && !busy_i
        |=> deep_sleep_o && ps_q == dsr_pkg::DSR_PS_SLEEP)
        else $error("entry opcode did not sleep");
    chk_busy_block: assert property (
        ps_q == dsr_pkg::DSR_PS_STANDBY && cs_rise && busy_i |=> !deep_sleep_o)
        else $error("entered sleep while busy");
    chk_out_start: assert property (
        active && sck_fall && rel_q && bit_q == `DSR_STREAM_START |=> miso_oe_o)
        else $error("identifier output not started");
    chk_no_early: assert property (
        active && bit_q < `DSR_STREAM_START |-> !miso_oe_o)
        else $error("output driven before dummy cycles end");
    chk_out_stop: assert property (
        cs_rise |=> !miso_oe_o ##1 !miso_oe_o)
        else $error("output not released at frame end");

    cov_wake: cover property (ps_q == dsr_pkg::DSR_PS_WAKE ##1 ps_q == dsr_pkg::DSR_PS_WAKE);
    cov_stream: cover property (miso_oe_o && load && sck_fall);
    cov_sleep: cover property (!deep_sleep_o ##1 deep_sleep_o);
endmodule : dsr_top

`default_nettype wire

/* File: dsr_host.sv */
// host serial controller model driving the release path pins
// assumes sys_clk_i at 25 MHz; link clock 320 ns, idle high
`timescale 1ns/1ps
`default_nettype none
`include "dsr_regs.svh"

module dsr_host (
    input wire logic sys_clk_i,
    input wire logic miso_i,
    input wire logic miso_oe_i,
    output logic cs_n_o,
    output logic sclk_o,
    output logic mosi_o
);
    logic [15:0] got_word;
    int oe_bad;
    event word_ev;

    // ****************************************************************
    // frame driver
    // ****************************************************************
    // pins idle: chip select high, serial clock parked high
    initial
    begin
        cs_n_o = 1'b1;
        sclk_o = 1'b1;
        mosi_o = 1'b0;
        got_word = 16'h0000;
        oe_bad = 0;
    end

    // opcode then n_clk more clocks; data sampled mid high phase, clear of both edges
    task automatic frame(input logic [7:0] op, input int n_clk);
        int k;
        @(posedge sys_clk_i);
        #1;
        cs_n_o = 1'b0;
        #160;
        for (k = 0; k < 8 + n_clk; k++)
        begin
            sclk_o = 1'b0;
            mosi_o = (k < 8) ? op[7 - k] : ~mosi_o; // toggled each clock after opcode
            #160;
            sclk_o = 1'b1;
            #80;
            if (op == `DSR_OP_RELEASE && k >= 8 + `DSR_DUMMY_CLKS) // three dummies
            begin
                if (miso_oe_i !== 1'b1)
                    oe_bad++;
                got_word = {got_word[14:0], miso_i};
                if ((k - 11) % 16 == 15)
                    -> word_ev;
            end
            #80;
        end
        cs_n_o = 1'b1; // frame ends with no further clocks
        mosi_o = ~mosi_o;
        #160;
    endtask : frame

    // own timer for the return to standby, no peeking at the device
    task automatic wait_standby();
        repeat (`DSR_SBR_CYCLES + 8) @(posedge sys_clk_i);
    endtask : wait_standby
endmodule : dsr_host

`default_nettype wire

/* File: deep_sleep_release_id_bench.sv */
// self-checking bench for the deep sleep release command path
// assumes dsr_host as the far side and a random identifier source
`timescale 1ns/1ps
`default_nettype none
`include "dsr_regs.svh"

module deep_sleep_release_id_bench;
    logic sys_clk_i, rst_i, busy_i, part_id_valid_i, part_id_ready_o;
    logic cs_n, sclk, mosi, miso_o, miso_oe_o, deep_sleep_o, standby_o;
    dsr_pkg::dsr_word_t part_id_i;
    dsr_pkg::dsr_word_t exp_q[$];
    logic [7:0] ops [3];
    int fail_count, n_checks, seed, i;

    dsr_top dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .sclk_i(sclk),
        .mosi_i(mosi), .busy_i(busy_i), .part_id_i(part_id_i),
        .part_id_valid_i(part_id_valid_i), .part_id_ready_o(part_id_ready_o),
        .miso_o(miso_o), .miso_oe_o(miso_oe_o), .deep_sleep_o(deep_sleep_o),
        .standby_o(standby_o));

    dsr_host host (.sys_clk_i(sys_clk_i), .miso_i(miso_o), .miso_oe_i(miso_oe_o),
        .cs_n_o(cs_n), .sclk_o(sclk), .mosi_o(mosi));

    // ****************************************************************
    // clock, checks and verdict
    // ****************************************************************
    initial
    begin
        sys_clk_i = 1'b0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            $display("mismatch %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask : check

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done

    // settle a few clocks, then compare power state and output enable
    task automatic state(input logic sleep, input logic stby);
        repeat (6) @(posedge sys_clk_i);
        check("deep_sleep_o", {15'h0000, sleep}, {15'h0000, deep_sleep_o});
        check("standby_o", {15'h0000, stby}, {15'h0000, standby_o});
        check("miso_oe_o", 16'h0000, {15'h0000, miso_oe_o});
    endtask : state

    // source driver notes each word as the buffer takes it; order must survive
    always @(posedge sys_clk_i)
        if (!rst_i && part_id_valid_i && part_id_ready_o)
        begin
            exp_q.push_back(part_id_i);
            #1 part_id_i = 16'($random(seed));
        end

    // each word the host collects is matched against the oldest note
    always @(host.word_ev)
        check("part_identifier", (exp_q.size() > 0) ? exp_q.pop_front() : 16'hXXXX,
            host.got_word);

    // watchdog: the whole sequence needs well under this
    initial
    begin
        repeat (20000) @(posedge sys_clk_i);
        fail_count++;
        test_done();
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        seed = 32'h8AA276B8;
        fail_count = 0;
        n_checks = 0;
        rst_i = 1'b1;
        busy_i = 1'b0;
        part_id_valid_i = 1'b0;
        part_id_i = 16'($random(seed));
        repeat (12) @(posedge sys_clk_i);
        #1 rst_i = 1'b0;
        part_id_valid_i = 1'b1;
        state(1'b0, 1'b1);
        // identifier read from standby: two whole words, no state change
        host.frame(`DSR_OP_RELEASE, 3 + 32);
        state(1'b0, 1'b1);
        // entry refused while program or erase runs
        @(posedge sys_clk_i);
        #1 busy_i = 1'b1;
        host.frame(`DSR_OP_ENTRY, 0);
        @(posedge sys_clk_i);
        #1 busy_i = 1'b0;
        state(1'b0, 1'b1);
        host.frame(`DSR_OP_ENTRY, 0);
        state(1'b1, 1'b0);
        // everything but the release opcode is ignored in sleep
        ops[0] = `DSR_OP_ENTRY;
        ops[1] = 8'($random(seed));
        ops[2] = 8'h00;
        for (i = 0; i < 3; i++)
        begin
            host.frame((ops[i] == `DSR_OP_RELEASE) ? 8'h00 : ops[i], 3 + 16);
            state(1'b1, 1'b0);
        end
        // release with identifier; an entry sent during the wake-up is dropped
        host.frame(`DSR_OP_RELEASE, 3 + 32);
        state(1'b0, 1'b0);
        host.frame(`DSR_OP_ENTRY, 0);
        state(1'b0, 1'b0);
        host.wait_standby();
        state(1'b0, 1'b1);
        // plain release, opcode alone
        host.frame(`DSR_OP_ENTRY, 0);
        state(1'b1, 1'b0);
        host.frame(`DSR_OP_RELEASE, 0);
        state(1'b0, 1'b0);
        host.wait_standby();
        state(1'b0, 1'b1);
        check("oe during stream", 16'h0000, 16'(host.oe_bad));
        check("words left", 16'h0002, 16'(exp_q.size()));
        check("part_id_ready_o", 16'h0000, {15'h0000, part_id_ready_o});
        test_done();
    end
endmodule : deep_sleep_release_id_bench

`default_nettype wire
